// file: src/flex_io_fd_clone.sv
// Full-duplex and clone-mode data port of the flexible parallel interface
//
// Function
// - Full duplex: interleaved receive at twice rate
// - Full duplex: accept interleaved transmit at twice rate
// - Clone: two receive buses, one update per sample
// - Clone: transmit interleaved on one bus
// - Clone only via serial programming, never pins
// - Full duplex: transmit on upper bus, receive on lower
// - Channel select high A, low B routes
// - Receive indicator low A, high B
// - Buffered transmit clock, one edge per word
`timescale 1ns/1ps
`default_nettype none
module flex_io_fd_clone (
    input  wire logic                                 clk_sys_i,          // Twice-sample-rate word clock
    input  wire logic                                 rst_i,              // Asynchronous reset, active high
    input  wire logic                                 ce_i,               // Clock enable, freezes state when low
    input  wire logic                                 full_duplex_mode_i, // Mode pin input, unread; full duplex whenever the serial enable is low
    input  wire logic                                 clone_serial_en_i,  // Clone selected by serial programming
    input  wire logic                                 sample_tick_i,      // One pulse per converter sample
    input  wire flex_io_pkg::sample_pair_t            rx_pair_i,          // Receive sample pair from converters
    input  wire logic [flex_io_pkg::SAMPLE_W-1:0]     upper_data_bus_i,   // Interleaved transmit words
    input  wire logic                                 tx_channel_select_i,// High for A word, low for B word
    output logic      [flex_io_pkg::SAMPLE_W-1:0]     upper_data_bus_o,   // Clone receive channel B
    output logic                                      upper_data_bus_oe_o,// Upper bus driven by device
    output logic      [flex_io_pkg::SAMPLE_W-1:0]     lower_data_bus_o,   // Interleaved rx, or clone channel A
    output logic                                      lower_data_bus_oe_o,// Lower bus driven by device
    output logic                                      rx_channel_indicator_pin_o, // Low A, high B
    output logic                                      buffered_clock_pin_o,       // One edge per tx word
    output flex_io_pkg::sample_pair_t                 tx_pair_o,          // Assembled transmit pair
    output logic                                      tx_pair_valid_o     // One-cycle pulse per pair
);

    // Mode state
    flex_io_pkg::port_mode_t mode_q, mode_d;
    // Receive interleave state
    flex_io_pkg::sample_pair_t rx_hold_q, rx_hold_d;  // Pair captured at sample tick
    logic                      rx_phase_q, rx_phase_d;// High while A word is out
    logic [flex_io_pkg::SAMPLE_W-1:0] up_q, up_d, lo_q, lo_d;
    logic                      up_oe_q, up_oe_d, lo_oe_q, lo_oe_d, ind_q, ind_d;
    // Transmit state
    logic [flex_io_pkg::SAMPLE_W-1:0] tx_a_q, tx_a_d;  // Held A word awaiting B
    flex_io_pkg::sample_pair_t tx_q, tx_d;
    logic                      tx_v_q, tx_v_d, clk_out_q, clk_out_d;

    // Mode test shared by the full-duplex checks
    function automatic logic is_full_duplex(input flex_io_pkg::port_mode_t mode_v);
        return (mode_v == flex_io_pkg::MODE_FULL_DUPLEX);
    endfunction

    // Mode decode: pins can only reach full duplex
    always_comb begin
        if (clone_serial_en_i) begin
            mode_d = flex_io_pkg::MODE_CLONE;
        end else begin
            mode_d = flex_io_pkg::MODE_FULL_DUPLEX;
        end
    end

    // Receive path next values
    always_comb begin
        rx_hold_d  = rx_hold_q;
        rx_phase_d = rx_phase_q;
        up_d = up_q;
        lo_d = lo_q;
        up_oe_d = 1'b0;
        lo_oe_d = 1'b1;
        ind_d = ind_q;
        case (mode_q)
            flex_io_pkg::MODE_FULL_DUPLEX: begin
                // Lower bus alternates A then B each clock
                if (sample_tick_i) begin
                    rx_hold_d  = rx_pair_i;
                    lo_d       = rx_pair_i.chan_a;
                    ind_d      = flex_io_pkg::RX_IND_CHAN_A;
                    rx_phase_d = 1'b1;
                end else if (rx_phase_q) begin
                    lo_d       = rx_hold_q.chan_b;
                    ind_d      = flex_io_pkg::RX_IND_CHAN_B;
                    rx_phase_d = 1'b0;
                end
            end
            flex_io_pkg::MODE_CLONE: begin
                // Both buses update once per sample; upper becomes an output
                up_oe_d    = 1'b1;
                rx_phase_d = 1'b0;
                if (sample_tick_i) begin
                    lo_d = rx_pair_i.chan_a;
                    up_d = rx_pair_i.chan_b;
                end
            end
            default: begin
                lo_oe_d = 1'b0;
            end
        endcase
    end

    // Transmit path next values
    always_comb begin
        tx_a_d    = tx_a_q;
        tx_d      = tx_q;
        tx_v_d    = 1'b0;
        clk_out_d = ~clk_out_q;
        if (tx_channel_select_i == flex_io_pkg::TX_SEL_CHAN_A) begin
            tx_a_d = upper_data_bus_i;
        end else begin
            tx_d.chan_a = tx_a_q;
            tx_d.chan_b = upper_data_bus_i;
            tx_v_d      = 1'b1;
        end
    end

    // Mode register; full duplex out of reset
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            mode_q <= flex_io_pkg::MODE_FULL_DUPLEX;
        end else if (ce_i) begin
            mode_q <= mode_d;
        end
    end

    // Receive path registers, bus drivers and indicator
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rx_hold_q  <= '0;
            rx_phase_q <= 1'b0;
            up_q       <= flex_io_pkg::WORD_RESET;
            lo_q       <= flex_io_pkg::WORD_RESET;
            up_oe_q    <= 1'b0;
            lo_oe_q    <= 1'b0;
            ind_q      <= flex_io_pkg::RX_IND_CHAN_A;
        end else if (ce_i) begin
            rx_hold_q  <= rx_hold_d;
            rx_phase_q <= rx_phase_d;
            up_q       <= up_d;
            lo_q       <= lo_d;
            up_oe_q    <= up_oe_d;
            lo_oe_q    <= lo_oe_d;
            ind_q      <= ind_d;
        end
    end

    // Transmit path registers and buffered clock toggle
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            tx_a_q     <= flex_io_pkg::WORD_RESET;
            tx_q       <= '0;
            tx_v_q     <= 1'b0;
            clk_out_q  <= 1'b0;
        end else if (ce_i) begin
            tx_a_q     <= tx_a_d;
            tx_q       <= tx_d;
            tx_v_q     <= tx_v_d;
            clk_out_q  <= clk_out_d;
        end
    end

    // Outputs straight from flip-flops
    assign upper_data_bus_o           = up_q;
    assign upper_data_bus_oe_o        = up_oe_q;
    assign lower_data_bus_o           = lo_q;
    assign lower_data_bus_oe_o        = lo_oe_q;
    assign rx_channel_indicator_pin_o = ind_q;
    assign buffered_clock_pin_o       = clk_out_q;
    assign tx_pair_o                  = tx_q;
    assign tx_pair_valid_o            = tx_v_q;

    // Clone follows the serial enable alone, one enabled cycle later
    chk_clone_needs_serial: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ce_i |=> ((mode_q == flex_io_pkg::MODE_CLONE) == $past(clone_serial_en_i)))
        else $error("clone mode not following serial enable");

    // Mode pins without the serial enable only give full duplex
    chk_pin_mode: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ce_i && full_duplex_mode_i && !clone_serial_en_i |=> is_full_duplex(mode_q))
        else $error("mode pins did not give full duplex");

    // A word follows a tick, B word the next cycle
    sequence rx_a_out;
        ce_i && is_full_duplex(mode_q) && sample_tick_i;
    endsequence
    // Enabled full-duplex cycle without a tick
    sequence rx_b_out;
        ce_i && is_full_duplex(mode_q) && !sample_tick_i;
    endsequence
    chk_rx_interleave: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        rx_a_out ##1 rx_b_out
        |=> (lower_data_bus_o == $past(rx_pair_i.chan_b, 2)))
        else $error("interleaved B word wrong");
    chk_rx_ind_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        rx_a_out |=> (rx_channel_indicator_pin_o == flex_io_pkg::RX_IND_CHAN_A
                      && lower_data_bus_o == $past(rx_pair_i.chan_a)))
        else $error("indicator not low with A word");
    chk_rx_ind_b: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        rx_a_out ##1 rx_b_out |=> rx_channel_indicator_pin_o == flex_io_pkg::RX_IND_CHAN_B)
        else $error("indicator not high with B word");

    // Bus directions follow the registered mode one cycle later
    chk_fd_bus_dir: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ce_i && is_full_duplex(mode_q) |=> lower_data_bus_oe_o && !upper_data_bus_oe_o)
        else $error("full duplex bus directions wrong");
    chk_clone_oe: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ce_i && mode_q == flex_io_pkg::MODE_CLONE |=> upper_data_bus_oe_o && lower_data_bus_oe_o)
        else $error("clone buses not both driven");
    chk_clone_rx: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ce_i && mode_q == flex_io_pkg::MODE_CLONE && sample_tick_i
        |=> upper_data_bus_o == $past(rx_pair_i.chan_b) && lower_data_bus_o == $past(rx_pair_i.chan_a))
        else $error("clone buses not updated");
    chk_tx_pairing: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ce_i && tx_channel_select_i ##1 ce_i && !tx_channel_select_i
        |=> tx_pair_valid_o && tx_pair_o.chan_a == $past(upper_data_bus_i, 2)
            && tx_pair_o.chan_b == $past(upper_data_bus_i))
        else $error("transmit pair misrouted");
    // An A word alone never completes a pair
    chk_tx_a_held: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ce_i && tx_channel_select_i == flex_io_pkg::TX_SEL_CHAN_A |=> !tx_pair_valid_o)
        else $error("pair valid raised on an A word");

    // Buffered clock flips on every enabled cycle
    chk_tx_clock: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ce_i |=> buffered_clock_pin_o != $past(buffered_clock_pin_o))
        else $error("buffered clock not toggling");
    // Without the clock enable the outputs hold still
    chk_ce_freeze: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !ce_i |=> $stable(buffered_clock_pin_o) && $stable(lower_data_bus_o) && $stable(tx_pair_valid_o))
        else $error("outputs moved with clock enable low");

endmodule
`default_nettype wire

// file: src/flex_io_pkg.sv
// Shared constants and carrier types for the flexible full-duplex and clone-mode data port
package flex_io_pkg;

    localparam int unsigned SAMPLE_W = 12;       // Converter word width

    // Interface mode selection
    typedef enum logic [1:0] {
        MODE_FULL_DUPLEX = 2'b01,
        MODE_CLONE       = 2'b10
    } port_mode_t;

    // Transmit channel-select level meaning channel A
    localparam logic TX_SEL_CHAN_A = 1'b1;
    // Receive indicator levels
    localparam logic RX_IND_CHAN_A = 1'b0;
    localparam logic RX_IND_CHAN_B = 1'b1;

    // Reset value of data words
    localparam logic [SAMPLE_W-1:0] WORD_RESET = 12'h000;

    // One pair of channel samples
    typedef struct packed {
        logic [SAMPLE_W-1:0] chan_a;
        logic [SAMPLE_W-1:0] chan_b;
    } sample_pair_t;

endpackage

// file: sim/back_end_model.sv
// Back-end model that launches interleaved transmit words
`timescale 1ns/1ps
`default_nettype none
module back_end_model (
    input  wire logic                              clk_i,  // Word clock from the device
    input  wire logic                              en_i,   // Launch words while high
    output logic      [flex_io_pkg::SAMPLE_W-1:0]  word_o, // Transmit word
    output logic                                   sel_o   // High with an A word
);
    logic [flex_io_pkg::SAMPLE_W-1:0] n_q = 12'h000; // Pair count
    logic                             go;            // Enable seen at the edge
    initial begin
        word_o = 12'h000;
        sel_o  = 1'b0;
    end
    // Launch just after the device clock edge
    always @(posedge clk_i) begin
        go = en_i;
        #1;
        if (go) begin
            sel_o  <= ~sel_o;
            word_o <= sel_o ? 12'hA00 + n_q : 12'h200 + n_q;
            n_q    <= n_q + {11'h000, sel_o};
        end else begin
            // Released bus inverts the last word each clock
            word_o <= ~word_o;
            sel_o  <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the full-duplex and clone data port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic                      clk_sys_i = 1'b0; // Word clock
    logic                      rst_i     = 1'b1; // Reset
    logic                      ce_i      = 1'b1; // Clock enable
    logic                      fdm = 1'b1, cln = 1'b0, tick = 1'b0, pen = 1'b0;
    flex_io_pkg::sample_pair_t rxp = '0, txp, pp;
    logic [11:0]               ubus, uo, lo, a, w;
    logic                      tsel, uoe, loe, ind, bclk, txv, s, pv, c, seen, b;
    int                        err_count = 0, cmp_count = 0;
    always #2 clk_sys_i = ~clk_sys_i;
    flex_io_fd_clone i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
        .full_duplex_mode_i(fdm), .clone_serial_en_i(cln), .sample_tick_i(tick),
        .rx_pair_i(rxp), .upper_data_bus_i(ubus), .tx_channel_select_i(tsel),
        .upper_data_bus_o(uo), .upper_data_bus_oe_o(uoe), .lower_data_bus_o(lo),
        .lower_data_bus_oe_o(loe), .rx_channel_indicator_pin_o(ind),
        .buffered_clock_pin_o(bclk), .tx_pair_o(txp), .tx_pair_valid_o(txv));
    back_end_model i_be (.clk_i(clk_sys_i), .en_i(pen), .word_o(ubus), .sel_o(tsel));
    task check(input bit ok, input string m);
        cmp_count++;
        if (!ok) begin
            err_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    // Back-to-back samples come out A then B on the lower bus
    task t_rx;
        for (logic [11:0] k = 12'h101; k < 12'h104; k++) begin
            tick = 1'b1;
            rxp  = {k, ~k};
            cyc(1);
            tick = 1'b0;
            check(lo === k && ind === 1'b0 && loe === 1'b1 && uoe === 1'b0, "rx A");
            cyc(1);
            check(lo === ~k && ind === 1'b1, "rx B");
        end
    endtask
    // Transmit words pair up A then B and emerge as one pair
    task t_tx;
        pen  = 1'b1;
        pv   = 1'b0;
        seen = 1'b0;
        repeat (10) begin
            @(posedge clk_sys_i);
            c  = seen;
            s  = tsel;
            w  = ubus;
            if (s) a = w;
            pv   = !s;
            pp   = {a, w};
            seen = seen | s;
            @(negedge clk_sys_i);
            if (c) check(txv === pv && (!pv || txp === pp), "tx pair");
        end
        cyc(1);
        pen = 1'b0;
        cyc(1);
    endtask
    // Buffered clock toggles per enabled cycle, freezes without enable
    task t_clk;
        repeat (4) begin
            b = bclk;
            cyc(1);
            check(bclk === ~b, "clock toggle");
        end
        ce_i = 1'b0;
        b    = bclk;
        cyc(3);
        check(bclk === b, "clock frozen");
        ce_i = 1'b1;
    endtask
    // Pins never reach clone; serial select gives two receive buses
    task t_clone;
        fdm = 1'b0;
        cyc(2);
        check(uoe === 1'b0, "pins cloned");
        cln = 1'b1;
        cyc(2);
        tick = 1'b1;
        rxp  = {12'h3A5, 12'h5C3};
        cyc(1);
        tick = 1'b0;
        check(lo === 12'h3A5 && uo === 12'h5C3 && uoe === 1'b1 && loe === 1'b1, "clone rx");
        cyc(1);
        check(lo === 12'h3A5 && uo === 12'h5C3, "clone held");
        t_tx();
        cln = 1'b0;
        fdm = 1'b1;
    endtask
    task tally_and_finish;
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #20000;
        err_count++;
        tally_and_finish();
    end
    initial begin
        repeat (5) @(posedge clk_sys_i);
        #1;
        check(lo === 12'h000 && uo === 12'h000 && txp === '0 && txv === 1'b0 && bclk === 1'b0
              && loe === 1'b0 && uoe === 1'b0 && ind === 1'b0, "reset outputs");
        rst_i = 1'b0;
        cyc(2);
        fork
            t_rx();
            t_tx();
        join
        t_clk();
        t_clone();
        tally_and_finish();
    end
endmodule
`default_nettype wire
